/* logic/fcm_monitor.sv */
// Contract
// - Monitor runs only when the monitor enable fuse is set.
// - Slow internal RC runs continuously while monitoring is enabled.
// - Sample clock is the slow internal RC divided by 64.
// - Latch sets on device clock fall, clears on sample clock rise.
// - At sample clock fall a still-set latch means clock failure.
// - Failure sets the oscillator fail flag, bit 7 of flags register 2.
// - Failure switches to internal block; oscillator select register unchanged.
// - Failure clears the watchdog counter and its postscaler.
// - Only primary and secondary sources are supervised; internal failure ignored.
// - Watchdog disable never stops the slow RC while monitoring.
// - Fail-safe ends only on device reset or power-managed mode entry; the code also ends it on wake_i.
// - After reset run internal until primary ready, then switch and set status.
// - If primary never readies, stay internal with select register at reset value.
// - Power-managed entry selects the register's source and resumes monitoring.
// - Failure in power-managed mode with interrupt enabled stays on internal.
// - With interrupt disabled, an idle interrupt resumes the processor on internal.
// - Non-crystal modes start monitoring right after reset or wake.
// - Crystal modes run internal until timers expire, then monitoring resumes.
// - A primary failing to start is never flagged as a failure.
// - Selecting a secondary or internal power-managed source during start-up disables the primary.
// - Running status is one on primary clock, zero on internal block.
`timescale 1ns/100ps
module fcm_monitor
  import fcm_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Configuration.
  input wire logic monitor_enable_fuse_i,
  input wire fcm_mode_type primary_mode_i,
  input wire logic watchdog_enable_i,
  // Clock levels, sampled.
  input wire logic slow_internal_rc_i,
  input wire logic primary_clk_i,
  input wire logic secondary_clk_i,
  // Start-up and power events.
  input wire logic wake_i,
  input wire logic startup_done_i,
  input wire logic pm_enter_i,
  input wire fcm_src_type pm_src_i,
  input wire logic idle_i,
  input wire logic irq_any_i,
  // Software control.
  input wire logic osc_fail_ie_i,
  input wire logic flag_clear_i,
  // Status.
  output logic osc_fail_flag_o,
  output logic [7:0] periph_irq_flags_2_o,
  output logic fail_safe_o,
  output logic primary_running_status_o,
  output fcm_src_type osc_select_reg_o,
  output fcm_src_type clk_sel_o,
  // Control of neighbouring blocks.
  output logic slow_rc_en_o,
  output logic primary_osc_en_o,
  output logic watchdog_clear_o,
  output logic cpu_resume_o
);

  fcm_state_type state;
  fcm_state_type next_state;
  fcm_src_type clk_sel;
  fcm_src_type next_clk_sel;
  fcm_src_type osc_sel;
  fcm_src_type next_osc_sel;
  logic running;
  logic next_running;
  logic osc_fail_flag;
  logic next_flag;
  logic in_pm;
  logic next_in_pm;
  logic pri_en;
  logic next_pri_en;
  logic wdt_clr;
  logic next_wdt_clr;
  logic resume;
  logic next_resume;
  logic armed;
  logic fail_det;
  logic dev_clk;
  logic sample_rise;
  logic sample_fall;
  logic watch_latch;

  // Monitoring needs the fuse, a settled source and an external source.
  assign armed = monitor_enable_fuse_i
    && (state == ST_RUN)
    && fcm_is_external(clk_sel);
  assign dev_clk = (clk_sel == SRC_SECONDARY) ? secondary_clk_i : primary_clk_i;

  // The RC keeps running for the monitor, whatever the watchdog does.
  assign slow_rc_en_o = monitor_enable_fuse_i | watchdog_enable_i;

  fcm_sample_div u_div (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .slow_internal_rc_i(slow_internal_rc_i),
    .sample_level_o(),
    .sample_rise_o(sample_rise),
    .sample_fall_o(sample_fall)
  );

  fcm_edge_watch u_watch (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .dev_clk_i(dev_clk),
    .sample_rise_i(sample_rise),
    .sample_fall_i(sample_fall),
    .arm_i(armed),
    .fail_o(fail_det),
    .latch_o(watch_latch)
  );

  // Source selection state.
  always_comb begin
    next_state = state;
    next_clk_sel = clk_sel;
    next_osc_sel = osc_sel;
    next_running = running;
    next_in_pm = in_pm;
    next_pri_en = pri_en;
    next_wdt_clr = 1'b0;
    next_resume = 1'b0;
    if (wake_i) begin
      next_state = ST_START;
      next_clk_sel = SRC_INTERNAL;
      next_running = 1'b0;
      next_pri_en = 1'b1;
      next_in_pm = 1'b0;
    end else begin
      case (state)
        ST_START: begin
          if (pm_enter_i) begin
            next_state = ST_RUN;
            next_osc_sel = pm_src_i;
            next_clk_sel = pm_src_i;
            next_running = (pm_src_i == SRC_PRIMARY);
            next_pri_en = (pm_src_i == SRC_PRIMARY);
            next_in_pm = 1'b1;
          end else if (!fcm_is_crystal(primary_mode_i) || startup_done_i) begin
            next_state = ST_RUN;
            next_clk_sel = SRC_PRIMARY;
            next_running = 1'b1;
          end
        end
        ST_RUN: begin
          if (fail_det) begin
            next_state = ST_FAILSAFE;
            next_clk_sel = SRC_INTERNAL;
            next_running = 1'b0;
            next_wdt_clr = 1'b1;
          end else if (pm_enter_i) begin
            next_osc_sel = pm_src_i;
            next_clk_sel = pm_src_i;
            next_running = (pm_src_i == SRC_PRIMARY);
            next_pri_en = (pm_src_i == SRC_PRIMARY);
            next_in_pm = 1'b1;
          end
        end
        ST_FAILSAFE: begin
          if (pm_enter_i) begin
            next_state = ST_RUN;
            next_osc_sel = pm_src_i;
            next_clk_sel = pm_src_i;
            next_running = (pm_src_i == SRC_PRIMARY);
            next_pri_en = (pm_src_i == SRC_PRIMARY);
            next_in_pm = 1'b1;
          end else begin
            // Execution stays on the internal block; no automatic return.
            next_clk_sel = SRC_INTERNAL;
            next_resume = in_pm && !osc_fail_ie_i && idle_i && irq_any_i;
          end
        end
        default: begin
          next_state = ST_START;
          next_clk_sel = SRC_INTERNAL;
          next_running = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_START;
      clk_sel <= SRC_INTERNAL;
      osc_sel <= OSC_SELECT_RESET;
      running <= 1'b0;
      in_pm <= 1'b0;
      pri_en <= 1'b1;
      wdt_clr <= 1'b0;
      resume <= 1'b0;
    end else begin
      state <= next_state;
      clk_sel <= next_clk_sel;
      osc_sel <= next_osc_sel;
      running <= next_running;
      in_pm <= next_in_pm;
      pri_en <= next_pri_en;
      wdt_clr <= next_wdt_clr;
      resume <= next_resume;
    end
  end

  // Fail flag: a new failure wins over a clear in the same cycle.
  always_comb begin
    next_flag = fail_det | (osc_fail_flag & ~flag_clear_i);
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_fail_flag <= 1'b0;
    end else begin
      osc_fail_flag <= next_flag;
    end
  end

  assign osc_fail_flag_o = osc_fail_flag;
  assign periph_irq_flags_2_o = {osc_fail_flag, IRQ_OTHER_BITS};
  assign fail_safe_o = (state == ST_FAILSAFE);
  assign primary_running_status_o = running;
  assign osc_select_reg_o = osc_sel;
  assign clk_sel_o = clk_sel;
  assign primary_osc_en_o = pri_en;
  assign watchdog_clear_o = wdt_clr;
  assign cpu_resume_o = resume;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_failure;
    fail_det && !wake_i;
  endsequence

  sequence s_fallback;
    (clk_sel == SRC_INTERNAL) && fail_safe_o && watchdog_clear_o;
  endsequence

  sequence s_restart;
    (state == ST_START) && (clk_sel == SRC_INTERNAL) && !primary_running_status_o
      && primary_osc_en_o;
  endsequence

  sequence s_primary_on;
    (state == ST_RUN) && (clk_sel == SRC_PRIMARY) && primary_running_status_o;
  endsequence

  property p_fail_flag;
    s_failure |=> osc_fail_flag_o && periph_irq_flags_2_o[IRQ_FLAG_BIT];
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("Failure did not set flag.");

  property p_fallback;
    s_failure |=> s_fallback ##1 !watchdog_clear_o;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("Failure did not fall back.");

  property p_select_kept;
    s_failure |=> $stable(osc_select_reg_o);
  endproperty
  a_select_kept: assert property (p_select_kept) else $error("Select register changed.");

  property p_internal_ignored;
    (!monitor_enable_fuse_i || !fcm_is_external(clk_sel)) |-> !fail_det;
  endproperty
  a_internal_ignored: assert property (p_internal_ignored)
    else $error("Unwatched failure.");

  property p_failsafe_hold;
    (fail_safe_o && !pm_enter_i && !wake_i) |=> fail_safe_o && clk_sel == SRC_INTERNAL;
  endproperty
  a_failsafe_hold: assert property (p_failsafe_hold)
    else $error("Fail-safe left early.");

  property p_pm_select;
    (pm_enter_i && !wake_i && !fail_det) |=> clk_sel == $past(pm_src_i) && osc_sel == clk_sel;
  endproperty
  a_pm_select: assert property (p_pm_select) else $error("Mode entry source wrong.");

  property p_rc_on;
    monitor_enable_fuse_i |-> slow_rc_en_o;
  endproperty
  a_rc_on: assert property (p_rc_on) else $error("Slow RC stopped.");

  property p_flag_hold;
    (osc_fail_flag && !flag_clear_i) |=> osc_fail_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Flag lost.");

  property p_status;
    primary_running_status_o == (clk_sel == SRC_PRIMARY && state == ST_RUN);
  endproperty
  a_status: assert property (p_status) else $error("Running status wrong.");

  property p_xtal_wait;
    (state == ST_START && fcm_is_crystal(primary_mode_i) && !startup_done_i && !pm_enter_i
      && !wake_i) |=> s_restart ##0 $stable(osc_select_reg_o);
  endproperty
  a_xtal_wait: assert property (p_xtal_wait) else $error("Start-up left early.");

  property p_start_no_fail;
    (state == ST_START) |-> !fail_det;
  endproperty
  a_start_no_fail: assert property (p_start_no_fail) else $error("Start-up flagged.");

  property p_pm_start_off;
    (state == ST_START && pm_enter_i && !wake_i && pm_src_i != SRC_PRIMARY) |=> !primary_osc_en_o;
  endproperty
  a_pm_start_off: assert property (p_pm_start_off) else $error("Primary left on.");

  property p_wake_restart;
    wake_i |=> s_restart;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("Wake restart wrong.");

  property p_immediate;
    (state == ST_START && !fcm_is_crystal(primary_mode_i) && !pm_enter_i && !wake_i)
      |=> s_primary_on;
  endproperty
  a_immediate: assert property (p_immediate) else $error("Late monitoring.");

  property p_ready_switch;
    (state == ST_START && startup_done_i && !pm_enter_i && !wake_i)
      |=> s_primary_on;
  endproperty
  a_ready_switch: assert property (p_ready_switch) else $error("No switch.");

  property p_select_only_pm;
    !pm_enter_i |=> $stable(osc_select_reg_o);
  endproperty
  a_select_only_pm: assert property (p_select_only_pm) else $error("Select moved.");

  property p_wdt_only_fail;
    !fail_det |=> !watchdog_clear_o;
  endproperty
  a_wdt_only_fail: assert property (p_wdt_only_fail) else $error("Spurious clear.");

  property p_resume;
    (fail_safe_o && in_pm && !osc_fail_ie_i && idle_i && irq_any_i && !pm_enter_i && !wake_i)
      |=> cpu_resume_o;
  endproperty
  a_resume: assert property (p_resume) else $error("No resume.");

  property p_no_resume;
    (!fail_safe_o || osc_fail_ie_i) |=> !cpu_resume_o;
  endproperty
  a_no_resume: assert property (p_no_resume) else $error("Spurious resume.");

  property p_latch_clear;
    !armed |=> !watch_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("Latch kept.");

endmodule

/* logic/fcm_pkg.sv */
package fcm_pkg;

  // Sample clock divider on the slow internal RC.
  localparam int DIV_RATIO = 64;
  localparam int DIV_WIDTH = 6;
  localparam logic [5:0] DIV_RESET = 6'h00;
  localparam logic [5:0] DIV_HALF_LAST = 6'h1F;
  localparam logic [5:0] DIV_FULL_LAST = 6'h3F;

  // Flag position in the peripheral interrupt flag register 2.
  localparam int IRQ_FLAG_BIT = 7;
  localparam logic [6:0] IRQ_OTHER_BITS = 7'h00;

  // Clock sources selectable on the device clock multiplexer.
  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'b00,
    SRC_SECONDARY = 2'b01,
    SRC_INTERNAL = 2'b10,
    SRC_INTERNAL_ALT = 2'b11
  } fcm_src_type;

  localparam fcm_src_type OSC_SELECT_RESET = SRC_PRIMARY;

  // Primary oscillator modes from the configuration fuses.
  typedef enum logic [2:0] {
    MODE_EXTERNAL_CLOCK = 3'b000,
    MODE_RC = 3'b001,
    MODE_INTERNAL_RC = 3'b010,
    MODE_LOW_POWER_CRYSTAL = 3'b011,
    MODE_STD_CRYSTAL = 3'b100,
    MODE_FAST_CRYSTAL = 3'b101,
    MODE_FAST_CRYSTAL_PLL = 3'b110,
    MODE_SPARE = 3'b111
  } fcm_mode_type;

  // Monitor control states.
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RUN = 2'b01,
    ST_FAILSAFE = 2'b10,
    ST_SPARE = 2'b11
  } fcm_state_type;

  // True when the source is an external primary or secondary clock.
  function automatic logic fcm_is_external(input fcm_src_type src);
    fcm_is_external = (src == SRC_PRIMARY) || (src == SRC_SECONDARY);
  endfunction

  // True for crystal and resonator modes that need start-up timers.
  function automatic logic fcm_is_crystal(input fcm_mode_type mode);
    case (mode)
      MODE_LOW_POWER_CRYSTAL, MODE_STD_CRYSTAL, MODE_FAST_CRYSTAL,
      MODE_FAST_CRYSTAL_PLL: fcm_is_crystal = 1'b1;
      default: fcm_is_crystal = 1'b0;
    endcase
  endfunction

endpackage

/* logic/fcm_sample_div.sv */
`timescale 1ns/100ps
module fcm_sample_div
  import fcm_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Slow internal RC level, sampled.
  input wire logic slow_internal_rc_i,
  // Sample clock level and edges.
  output logic sample_level_o,
  output logic sample_rise_o,
  output logic sample_fall_o
);

  logic rc_q;
  logic [5:0] cnt;
  logic rise_q;
  logic fall_q;
  logic [5:0] next_cnt;
  logic next_rise;
  logic next_fall;
  logic rc_rise;

  // The count advances on each RC rising edge and wraps every 64 edges.
  always_comb begin
    rc_rise = slow_internal_rc_i & ~rc_q;
    next_cnt = cnt;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (rc_rise) begin
      next_cnt = cnt + 6'h01;
      next_rise = (cnt == DIV_HALF_LAST);
      next_fall = (cnt == DIV_FULL_LAST);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rc_q <= 1'b0;
      cnt <= DIV_RESET;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rc_q <= slow_internal_rc_i;
      cnt <= next_cnt;
      rise_q <= next_rise;
      fall_q <= next_fall;
    end
  end

  assign sample_level_o = cnt[5];
  assign sample_rise_o = rise_q;
  assign sample_fall_o = fall_q;

  property p_div_rise;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (slow_internal_rc_i && !rc_q && cnt == DIV_HALF_LAST) |=> sample_rise_o && sample_level_o;
  endproperty
  a_div_rise: assert property (p_div_rise) else $error("Sample rise not on edge 32.");

endmodule

/* logic/fcm_edge_watch.sv */
`timescale 1ns/100ps
module fcm_edge_watch
  import fcm_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Monitored device clock level and sample clock edges.
  input wire logic dev_clk_i,
  input wire logic sample_rise_i,
  input wire logic sample_fall_i,
  input wire logic arm_i,
  // Failure pulse and latch state.
  output logic fail_o,
  output logic latch_o
);

  logic dev_q;
  logic edge_watch_latch;
  logic next_latch;
  logic dev_fall;

  // A device clock falling edge sets the latch; a sample rise clears it.
  always_comb begin
    dev_fall = dev_q & ~dev_clk_i;
    next_latch = edge_watch_latch;
    if (!arm_i) begin
      next_latch = 1'b0;
    end else if (dev_fall) begin
      next_latch = 1'b1;
    end else if (sample_rise_i) begin
      next_latch = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dev_q <= 1'b0;
      edge_watch_latch <= 1'b0;
    end else begin
      dev_q <= dev_clk_i;
      edge_watch_latch <= next_latch;
    end
  end

  // The latch still set at a sample fall, set by a device clock fall after the sample rise, signals failure.
  assign fail_o = arm_i & sample_fall_i & edge_watch_latch;
  assign latch_o = edge_watch_latch;

  property p_latch_set;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (arm_i && dev_q && !dev_clk_i) |=> edge_watch_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("Latch not set by clock fall.");

endmodule

/* verification/fcm_osc_model.sv */
`timescale 1ns/100ps
module fcm_osc_model (
  // Clock and gate.
  input wire logic core_clk_i,
  input wire logic run_i,
  // Oscillator levels.
  output logic primary_clk_o,
  output logic secondary_clk_o
);
  int pcnt = 0;
  int scnt = 0;
  logic go;

  initial begin
    primary_clk_o = 1'b1;
    secondary_clk_o = 1'b1;
  end

  // A stopped oscillator holds its last level, as a dead crystal does.
  always @(posedge core_clk_i) begin
    go = run_i;
    #2;
    if (go === 1'b1) begin
      pcnt = (pcnt + 1) % 3;
      scnt = (scnt + 1) % 5;
      if (pcnt == 0) begin
        primary_clk_o = ~primary_clk_o;
      end
      if (scnt == 0) begin
        secondary_clk_o = ~secondary_clk_o;
      end
    end
  end
endmodule

/* verification/tb.sv */
`timescale 1ns/100ps
module tb;
  import fcm_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic fuse = 1'b1, wdt_en = 1'b0, wake = 1'b0, done = 1'b0, pm = 1'b0;
  logic idle = 1'b0, irq = 1'b0, ie = 1'b1, fclr = 1'b0, rc = 1'b0, run = 1'b0;
  fcm_mode_type mode = MODE_EXTERNAL_CLOCK;
  fcm_src_type pm_src = SRC_PRIMARY;
  fcm_src_type osc_sel, clk_sel;
  logic pclk, sclk, flag, fs, status, rc_en, posc_en, wdclr, resume;
  logic [7:0] irqf;
  int cyc = 0, wd_cnt = 0, res_cnt = 0, bad_count = 0, check_count = 0, e_run = 0;
  logic e_flag = 1'b0, e_fs = 1'b0, e_stat = 1'b0;
  logic [1:0] e_osc = 2'h0, e_sel = 2'h2;

  fcm_osc_model osc (.core_clk_i(core_clk_i), .run_i(run), .primary_clk_o(pclk),
    .secondary_clk_o(sclk));

  fcm_monitor uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .monitor_enable_fuse_i(fuse), .primary_mode_i(mode), .watchdog_enable_i(wdt_en),
    .slow_internal_rc_i(rc), .primary_clk_i(pclk), .secondary_clk_i(sclk),
    .wake_i(wake), .startup_done_i(done), .pm_enter_i(pm), .pm_src_i(pm_src),
    .idle_i(idle), .irq_any_i(irq), .osc_fail_ie_i(ie), .flag_clear_i(fclr),
    .osc_fail_flag_o(flag), .periph_irq_flags_2_o(irqf), .fail_safe_o(fs),
    .primary_running_status_o(status), .osc_select_reg_o(osc_sel), .clk_sel_o(clk_sel),
    .slow_rc_en_o(rc_en), .primary_osc_en_o(posc_en), .watchdog_clear_o(wdclr),
    .cpu_resume_o(resume));

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  // Slow RC runs at a quarter of the core rate; pulses are counted once per cycle.
  always @(posedge core_clk_i) begin
    #2;
    rc = cyc[1];
    if (wdclr === 1'b1) begin
      wd_cnt++;
    end
    if (resume === 1'b1) begin
      res_cnt++;
    end
  end

  task automatic end_of_test();
    $display("counts: %0d comparisons, %0d mismatches", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step();
    @(posedge core_clk_i);
    #2;
  endtask

  task automatic chk_all();
    check({7'h00, flag}, {7'h00, e_flag});
    check(irqf, {e_flag, 7'h00});
    check({7'h00, fs}, {7'h00, e_fs});
    check({7'h00, status}, {7'h00, e_stat});
    check({6'h00, osc_sel}, {6'h00, e_osc});
    check({6'h00, clk_sel}, {6'h00, e_sel});
  endtask

  task automatic do_reset();
    rst_b_i = 1'b0;
    step();
    step();
    check({6'h00, clk_sel}, 8'h02);
    check({6'h00, osc_sel}, 8'h00);
    check({7'h00, status}, 8'h00);
    rst_b_i = 1'b1;
    step();
    step();
    e_run = (mode >= MODE_LOW_POWER_CRYSTAL && mode <= MODE_FAST_CRYSTAL_PLL) ? 0 : 1;
    e_flag = 1'b0;
    e_fs = 1'b0;
    e_osc = 2'h0;
    e_sel = (e_run == 1) ? 2'h0 : 2'h2;
    e_stat = (e_run == 1);
    chk_all();
  endtask

  // One sample period; mode 1 runs the clock while the sample clock is low, 2 while high.
  task automatic period(input int m);
    int w = 0;
    logic hit;
    while ((cyc % 256) != 10 && w < 600) begin
      step();
      w++;
    end
    if (w >= 600) begin
      bad_count++;
      $display("mismatch at %0t: no sample period alignment", $time);
      end_of_test();
    end
    hit = (m == 2) && fuse && (e_run == 1) && (e_sel[1] == 1'b0);
    wd_cnt = 0;
    for (int i = 0; i < 256; i++) begin
      run = (m == 1 && i > 10 && i < 100) || (m == 2 && i > 140 && i < 230);
      step();
    end
    if (hit) begin
      e_flag = 1'b1;
      e_fs = 1'b1;
      e_sel = 2'h2;
      e_stat = 1'b0;
      e_run = 0;
    end
    check(8'(wd_cnt), {7'h00, hit});
    chk_all();
  endtask

  task automatic pm_go(input fcm_src_type s);
    pm_src = s;
    pm = 1'b1;
    step();
    pm = 1'b0;
    step();
    e_osc = s;
    e_sel = s;
    e_stat = (s == SRC_PRIMARY);
    e_fs = 1'b0;
    e_run = 1;
  endtask

  task automatic clear_flag();
    fclr = 1'b1;
    step();
    fclr = 1'b0;
    step();
    e_flag = 1'b0;
    chk_all();
  endtask

  initial begin
    void'($urandom(32'hEDFED733));
    do_reset();
    check({7'h00, rc_en}, 8'h01);
    $display("test reset done");
    for (int k = 0; k < 5; k++) begin
      period(int'($urandom % 3));
    end
    period(2);
    clear_flag();
    period(2);
    $display("test primary monitor done");
    pm_go(SRC_SECONDARY);
    chk_all();
    period(1);
    period(2);
    period(1);
    ie = 1'b0;
    idle = 1'b1;
    irq = 1'b1;
    res_cnt = 0;
    repeat (4) step();
    check({7'h00, res_cnt > 0}, 8'h01);
    ie = 1'b1;
    idle = 1'b0;
    irq = 1'b0;
    clear_flag();
    pm_go(SRC_INTERNAL);
    period(2);
    $display("test power managed done");
    pm_go(SRC_PRIMARY);
    fuse = 1'b0;
    period(2);
    check({7'h00, rc_en}, 8'h00);
    wdt_en = 1'b1;
    step();
    check({7'h00, rc_en}, 8'h01);
    fuse = 1'b1;
    period(2);
    wake = 1'b1;
    step();
    wake = 1'b0;
    step();
    step();
    e_fs = 1'b0;
    e_sel = 2'h0;
    e_stat = 1'b1;
    e_run = 1;
    chk_all();
    $display("test fuse and wake done");
    for (int m = 0; m < 7; m++) begin
      mode = fcm_mode_type'(m);
      do_reset();
    end
    period(2);
    check({7'h00, posc_en}, 8'h01);
    done = 1'b1;
    step();
    step();
    e_sel = 2'h0;
    e_stat = 1'b1;
    e_run = 1;
    chk_all();
    period(2);
    done = 1'b0;
    wake = 1'b1;
    step();
    wake = 1'b0;
    step();
    pm_go(SRC_SECONDARY);
    check({7'h00, posc_en}, 8'h00);
    $display("test crystal start-up done");
    end_of_test();
  end
endmodule
